/* pkg/pmcr_pkg.sv */
// Purpose: Shared constants, types and helpers of the converter control registers
// Assumes: 250 MHz system clock, byte-wide register access
// Notes:   Offsets are byte addresses of the serial register map
package pmcr_pkg;
    // Clock
    localparam int unsigned CLK_PERIOD_NS = 4;
    // Register offsets
    localparam logic [7:0] ADDR_AUX_ENABLE = 8'h03;
    localparam logic [7:0] ADDR_PHASE_MODE = 8'h04;
    localparam logic [7:0] ADDR_DVM_DISCH  = 8'h05;
    localparam logic [7:0] ADDR_CORE_CODE  = 8'h06;
    localparam logic [7:0] ADDR_SLEW       = 8'h07;
    // Values after undervoltage lockout
    localparam logic [7:0] RST_PHASE_MODE  = 8'hb1;
    localparam logic [7:0] RST_DVM_DISCH   = 8'h40;
    localparam logic [2:0] RST_SLEW        = 3'h6;
    // Field positions
    localparam int unsigned PM_BUCK2_PH_LO = 6;
    localparam int unsigned PM_BUCK3_PH_LO = 4;
    localparam int unsigned PM_LOW_RIPPLE  = 3;
    localparam int unsigned DD_GO          = 7;
    localparam int unsigned DD_ADJ         = 6;
    localparam int unsigned AUX_ONE_BIT    = 1;
    // Core code mapping in millivolts
    localparam logic [4:0]  CODE_MAX       = 5'h1f;
    localparam logic [10:0] CORE_BASE_MV   = 11'h320;
    localparam logic [10:0] CORE_STEP_MV   = 11'h019;
    localparam logic [10:0] CORE_TOP_MV    = 11'h640;
    // Slew: one 25 mV step at the slowest rate of 0.15 mV/us
    localparam int unsigned SLEW_STEP_NS_SLOW = 166667;
    localparam int unsigned SLEW_STEP_CYC_SLOW =
        (SLEW_STEP_NS_SLOW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  SLEW_IMMEDIATE = 3'h7;

    // Phase delay codes
    typedef enum logic [1:0] {
        PMCR_PH_ZERO    = 2'h0,
        PMCR_PH_QUARTER = 2'h1,
        PMCR_PH_HALF    = 2'h2,
        PMCR_PH_THREE_Q = 2'h3
    } pmcr_phase_e;

    // Ramp engine states
    typedef enum logic {
        DVM_IDLE = 1'b0,
        DVM_RAMP = 1'b1
    } pmcr_dvm_e;

    // Device pins seen by the block, all active high unless named _n
    typedef struct packed {
        logic shared_aux_en;   // Shared auxiliary regulator enable pin
        logic aux_one_en;      // Auxiliary regulator one enable pin
        logic buck_one_en;     // First converter enable pin
        logic buck_three_en;   // Third converter enable pin
        logic warm_reset_n;    // Warm reset pin, low active
        logic por_active;      // Power-on reset output asserted
        logic backup_low;      // Backup supply below threshold
        logic core_sel;        // Core voltage select pin
    } pmcr_pins_s;

    // Converter control outputs; 3-bit fields ordered {buck2, buck1, buck3}
    typedef struct packed {
        pmcr_phase_e buck_one_phase;
        pmcr_phase_e buck_two_phase;
        pmcr_phase_e buck_three_phase;
        logic        low_ripple;
        logic [2:0]  force_fixed_frequency;
        logic [2:0]  discharge;
    } pmcr_conv_s;

    // Default core code from the select pin
    function automatic logic [4:0] default_code(input logic sel);
        default_code = {1'b1, sel, 1'b1, sel, 1'b0};
    endfunction : default_code

    // Core code to millivolts, top code is a special point
    // (R18) top code special point
    function automatic logic [10:0] code_to_mv(input logic [4:0] code);
        logic [10:0] prod;
        prod = CORE_STEP_MV * {6'h00, code};
        code_to_mv = (code == CODE_MAX) ? CORE_TOP_MV : CORE_BASE_MV + prod;
    endfunction : code_to_mv
endpackage : pmcr_pkg

/* hdl/pmcr_reset_events.sv */
// Purpose: Registers the pin conditions that reload register fields
// Assumes: Pins synchronous to clk_i
// Notes:   One cycle of latency from pin to event level
`timescale 1ns/1ps
module pmcr_reset_events
    import pmcr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Pins
    input  wire pmcr_pins_s pins_i,
    // Event levels
    output logic            mid_reload_o,
    output logic            ends_reload_o,
    output logic            aux_force_o
);
    // Causes common to both reload groups
    logic common_cause;
    assign common_cause = !pins_i.warm_reset_n || pins_i.por_active || pins_i.backup_low;

    // Event levels, asserted during lockout too
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mid_reload_o  <= 1'b1;
            ends_reload_o <= 1'b1;
            aux_force_o   <= 1'b1;
        end else begin
            // (R12) both enables low or common
            mid_reload_o  <= common_cause || (!pins_i.buck_one_en && !pins_i.buck_three_en);
            // (R16) first enable alone
            ends_reload_o <= common_cause || !pins_i.buck_one_en;
            // (R2) shared pin low
            aux_force_o   <= !pins_i.shared_aux_en;
        end
    end

    // (R16) ends group follows first enable
    AST_ENDS_ON_BUCK1: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !pins_i.buck_one_en |=> ends_reload_o) else $error("ends reload missed"); // R16
endmodule : pmcr_reset_events

/* hdl/pmcr_dvm_stepper.sv */
// Purpose: Ramps the internal core code toward the target at the slew rate
// Assumes: Go held high by the register until done
// Notes:   Clearing go mid-ramp freezes the code where it stands
`timescale 1ns/1ps
module pmcr_dvm_stepper
    import pmcr_pkg::*;
#(
    parameter int unsigned STEP_CYCLES_SLOW = SLEW_STEP_CYC_SLOW
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Control
    input  wire logic       go_i,
    input  wire logic [4:0] target_i,
    input  wire logic [2:0] slew_i,
    input  wire logic [4:0] init_code_i,
    // Status
    output logic [4:0]      code_o,
    output logic            done_o
);
    // Slowest code shifted six times must still be a cycle
    if (STEP_CYCLES_SLOW < 64 || STEP_CYCLES_SLOW > 32'h00ffffff) begin : g_chk
        $error("STEP_CYCLES_SLOW out of range");
    end

    pmcr_dvm_e   state;      // Ramp state
    logic [23:0] wait_cnt;   // Cycles left to next step
    logic [23:0] interval;   // Step interval for the slew code

    // Interval halves with each slew code
    assign interval = 24'(STEP_CYCLES_SLOW >> slew_i);

    // Ramp engine
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state    <= DVM_IDLE;
            wait_cnt <= 24'h000000;
            code_o   <= init_code_i;
            done_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                DVM_IDLE: begin
                    if (go_i) begin
                        state    <= DVM_RAMP;
                        wait_cnt <= interval - 24'h000001;
                    end
                end
                DVM_RAMP: begin
                    if (!go_i) begin
                        state <= DVM_IDLE;
                    // (R10) target reached ends it
                    end else if (code_o == target_i) begin
                        done_o <= 1'b1;
                        state  <= DVM_IDLE;
                    end else if (slew_i == SLEW_IMMEDIATE) begin
                        code_o <= target_i;
                    // (R20) one step per interval
                    end else if (wait_cnt == 24'h000000) begin
                        code_o   <= (code_o < target_i) ? code_o + 5'h01 : code_o - 5'h01;
                        wait_cnt <= interval - 24'h000001;
                    end else begin
                        wait_cnt <= wait_cnt - 24'h000001;
                    end
                end
            endcase
        end
    end

    // (R20) code moves one step unless immediate
    AST_DVM_ONE_STEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $changed(code_o) && $past(slew_i) != SLEW_IMMEDIATE && $past(rstn_i)
        |-> (code_o == $past(code_o) + 5'h01) || (code_o == $past(code_o) - 5'h01))
        else $error("code jumped"); // R20
    // (R10) done only at target
    AST_DVM_DONE_AT_TARGET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done_o |-> $past(code_o) == $past(target_i)) else $error("early done"); // R10
endmodule : pmcr_dvm_stepper

/* hdl/pmcr_converter_regs.sv */
// Purpose: Converter phase, mode, core voltage change and discharge registers
// Assumes: Register port is the byte side of the serial interface
// Notes:   rstn_i stands for undervoltage lockout; reads answer one cycle later
`timescale 1ns/1ps
// Contract
// (R1) Aux one on is bit AND pin
// (R2) Shared pin low forces aux bit to one
// (R3) Phase/mode register 04h, reset b1h
// (R4) Bits 7:6, 5:4 set converter phase delays
// (R5) First converter phase always zero
// (R6) Bit 3 picks low-ripple light-load behaviour
// (R7) Bits 2:0 force fixed frequency per converter
// (R8) Register 05h resets 40h, bits 5:3 zero
// (R9) Go bit starts core ramp to code
// (R10) Go clears when internal code hits target
// (R11) Adjust bit picks pin or register source
// (R12) Adjust bit returns to one on events
// (R13) Discharge bits act while converter disabled
// (R14) Core code 06h, five bits, pin default
// (R15) Code bits 3:1 reload on events
// (R16) Code bits 4, 0 reload on events
// (R17) Code below 31 is 800 mV plus 25n
// (R18) Code 31 selects 1600 mV
// (R19) Slew register 07h, default 6, doubling rates
// (R20) Ramp steps once per slew interval
// (R21) Lockout clears go bit
module pmcr_converter_regs
    import pmcr_pkg::*;
#(
    parameter int unsigned STEP_CYCLES_SLOW = SLEW_STEP_CYC_SLOW
) (
    // Clock and lockout reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Register access
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic [7:0]       reg_rdata_o,
    // Device pins and converter state
    input  wire pmcr_pins_s  pins_i,
    input  wire logic [2:0]  conv_enabled_i,
    // Regulator and converter controls
    output logic             aux_regulator_one_on_o,
    output pmcr_conv_s       conv_o,
    // Core rail
    output logic [4:0]       core_code_o,
    output logic [10:0]      core_rail_voltage_mv_o,
    output logic             core_pin_source_o,
    output logic             dvm_busy_o
);
    // Software state
    logic       aux_one_enable;   // Aux regulator one software enable
    logic [7:0] phase_mode;       // Phase and mode register
    logic       go;               // Core ramp request
    logic       adj_source;       // Core voltage from pin
    logic [2:0] discharge_en;     // Discharge enables {b2, b1, b3}
    logic [4:0] core_code;        // Core voltage code
    logic [2:0] core_slew_select; // Slew code
    // Internal links
    logic       mid_reload;       // Reload of adjust bit and code 3:1
    logic       ends_reload;      // Reload of code 4 and 0
    logic       aux_force;        // Shared pin low
    logic       ramp_done;        // Ramp reached target
    logic [4:0] target_code;      // Code the ramp heads for
    logic [4:0] pin_code;         // Pin default code
    logic [4:0] ramp_code;        // Internal code from the ramp
    logic [7:0] next_rdata;       // Read mux

    // Write decode per register
    logic wr_aux, wr_pm, wr_dd, wr_cc, wr_sl;
    assign wr_aux = reg_wr_i && reg_addr_i == ADDR_AUX_ENABLE;
    assign wr_pm  = reg_wr_i && reg_addr_i == ADDR_PHASE_MODE;
    assign wr_dd  = reg_wr_i && reg_addr_i == ADDR_DVM_DISCH;
    assign wr_cc  = reg_wr_i && reg_addr_i == ADDR_CORE_CODE;
    assign wr_sl  = reg_wr_i && reg_addr_i == ADDR_SLEW;

    // Pin default code
    assign pin_code = default_code(pins_i.core_sel);

    // (R11) pin source or register code
    assign target_code = adj_source ? pin_code : core_code;

    // Reload events
    pmcr_reset_events u_events (
        .clk_i         (clk_i),
        .rstn_i        (rstn_i),
        .pins_i        (pins_i),
        .mid_reload_o  (mid_reload),
        .ends_reload_o (ends_reload),
        .aux_force_o   (aux_force)
    );

    // Core ramp engine
    pmcr_dvm_stepper #(
        .STEP_CYCLES_SLOW (STEP_CYCLES_SLOW)
    ) u_stepper (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .go_i        (go),
        .target_i    (target_code),
        .slew_i      (core_slew_select),
        .init_code_i (pin_code),
        .code_o      (ramp_code),
        .done_o      (ramp_done)
    );

    // Aux regulator one software enable
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            aux_one_enable <= 1'b1;
        // (R2) force while shared pin low
        end else if (aux_force) begin
            aux_one_enable <= 1'b1;
        end else if (wr_aux) begin
            aux_one_enable <= reg_wdata_i[AUX_ONE_BIT];
        end
    end

    // Phase and mode register
    always_ff @(posedge clk_i) begin
        // (R3) lockout value
        if (!rstn_i) begin
            phase_mode <= RST_PHASE_MODE;
        end else if (wr_pm) begin
            phase_mode <= reg_wdata_i;
        end
    end

    // Go bit
    always_ff @(posedge clk_i) begin
        // (R21) lockout clears go
        if (!rstn_i) begin
            go <= RST_DVM_DISCH[DD_GO];
        // (R9) software start, set wins
        end else if (wr_dd && reg_wdata_i[DD_GO]) begin
            go <= 1'b1;
        // (R10) hardware clear at target
        end else if (ramp_done) begin
            go <= 1'b0;
        end else if (wr_dd) begin
            go <= 1'b0;
        end
    end

    // Adjust source bit
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            adj_source <= RST_DVM_DISCH[DD_ADJ];
        // (R12) event returns it to one
        end else if (mid_reload) begin
            adj_source <= 1'b1;
        end else if (wr_dd) begin
            adj_source <= reg_wdata_i[DD_ADJ];
        end
    end

    // Discharge enables
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            discharge_en <= RST_DVM_DISCH[2:0];
        end else if (wr_dd) begin
            discharge_en <= reg_wdata_i[2:0];
        end
    end

    // Core voltage code
    always_ff @(posedge clk_i) begin
        // (R14) pin default after lockout
        if (!rstn_i) begin
            core_code <= pin_code;
        end else begin
            if (wr_cc) begin
                core_code <= reg_wdata_i[4:0];
            end
            // (R15) middle bits reload
            if (mid_reload) begin
                core_code[3:1] <= pin_code[3:1];
            end
            // (R16) end bits reload
            if (ends_reload) begin
                core_code[4] <= pin_code[4];
                core_code[0] <= pin_code[0];
            end
        end
    end

    // Slew select
    always_ff @(posedge clk_i) begin
        // (R19) default slew code
        if (!rstn_i) begin
            core_slew_select <= RST_SLEW;
        end else if (wr_sl) begin
            core_slew_select <= reg_wdata_i[2:0];
        end
    end

    // Read mux, unmapped and unused bits read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr_i)
            ADDR_AUX_ENABLE: next_rdata[AUX_ONE_BIT] = aux_one_enable;
            ADDR_PHASE_MODE: next_rdata = phase_mode;
            // (R8) bits 5:3 read zero
            ADDR_DVM_DISCH:  next_rdata = {go, adj_source, 3'h0, discharge_en};
            ADDR_CORE_CODE:  next_rdata = {3'h0, core_code};
            ADDR_SLEW:       next_rdata = {5'h00, core_slew_select};
            default:         next_rdata = 8'h00;
        endcase
    end

    // Read data register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // Converter and regulator outputs
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            aux_regulator_one_on_o <= 1'b0;
            conv_o                 <= '0;
            core_rail_voltage_mv_o <= 11'h000;
            core_pin_source_o      <= 1'b1;
            dvm_busy_o             <= 1'b0;
        end else begin
            // (R1) bit AND pin
            aux_regulator_one_on_o <= aux_one_enable && pins_i.aux_one_en;
            // (R5) reference phase fixed
            conv_o.buck_one_phase <= PMCR_PH_ZERO;
            // (R4) phase delay fields
            conv_o.buck_two_phase   <= pmcr_phase_e'(phase_mode[PM_BUCK2_PH_LO +: 2]);
            conv_o.buck_three_phase <= pmcr_phase_e'(phase_mode[PM_BUCK3_PH_LO +: 2]);
            // (R6) light-load behaviour
            conv_o.low_ripple <= phase_mode[PM_LOW_RIPPLE];
            // (R7) forced fixed frequency
            conv_o.force_fixed_frequency <= phase_mode[2:0];
            // (R13) discharge only when disabled
            conv_o.discharge <= discharge_en & ~conv_enabled_i;
            // (R17) voltage from ramp code
            core_rail_voltage_mv_o <= code_to_mv(ramp_code);
            core_pin_source_o      <= adj_source;
            dvm_busy_o             <= go;
        end
    end

    // Internal code straight from the ramp flop
    assign core_code_o = ramp_code;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_go_written;
        wr_dd && reg_wdata_i[DD_GO];
    endsequence
    sequence s_ramp_finishes;
        ramp_done && !(wr_dd && reg_wdata_i[DD_GO]);
    endsequence

    AST_AUX_ON_AND: assert property ( // R1
        $past(rstn_i) |-> aux_regulator_one_on_o == $past(aux_one_enable && pins_i.aux_one_en))
        else $error("aux on mismatch");
    AST_AUX_FORCE: assert property ( // R2
        !pins_i.shared_aux_en |-> ##2 aux_one_enable) else $error("aux bit not forced");
    AST_PHASE_MODE_RESET: assert property ( // R3
        $rose(rstn_i) |-> phase_mode == RST_PHASE_MODE && !go) else $error("bad reset value");
    AST_BUCK_ONE_PHASE: assert property ( // R5
        conv_o.buck_one_phase == PMCR_PH_ZERO) else $error("reference phase moved");
    AST_FORCE_FIXED_FREQUENCY_MAP: assert property ( // R7
        wr_pm ##1 !wr_pm |-> ##1 conv_o.force_fixed_frequency == $past(reg_wdata_i[2:0], 2))
        else $error("fixed frequency map wrong");
    AST_GO_START: assert property ( // R9
        s_go_written |=> go ##1 dvm_busy_o) else $error("go not taken");
    AST_GO_CLEARS: assert property ( // R10
        s_ramp_finishes |=> !go) else $error("go not cleared");
    AST_ADJ_EVENT: assert property ( // R12
        mid_reload |=> adj_source && target_code == pin_code) else $error("adjust not reloaded");
    AST_CODE_MID: assert property ( // R15
        mid_reload && !wr_cc |=> core_code[3:1] == $past(pin_code[3:1]))
        else $error("code 3:1 not reloaded");
    AST_CODE_ENDS: assert property ( // R16
        ends_reload |=> core_code[4] && !core_code[0]) else $error("code ends not reloaded");
    AST_MV_TOP: assert property ( // R18
        ramp_code == CODE_MAX |=> core_rail_voltage_mv_o == CORE_TOP_MV)
        else $error("top code voltage wrong");
    AST_DISCHARGE: assert property ( // R13
        conv_enabled_i[1] |=> !conv_o.discharge[1]) else $error("discharge while enabled");
endmodule : pmcr_converter_regs

/* verification/pmcr_host_model.sv */
// Purpose: Host side of the byte register port
// Assumes: Requests launched just after a rising edge
// Notes:   Write data inverted when idle so stale bytes never look valid
`timescale 1ns/1ps
module pmcr_host_model (
    // Clock
    input  wire logic       clk_i,
    // Register port
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    // Idle port at time zero
    initial begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge clk_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~d;
    endtask : wr

    // Read, data taken once it has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        @(posedge clk_i);
        #1;
        d = reg_rdata_i;
    endtask : rd
endmodule : pmcr_host_model

/* verification/tb.sv */
// Purpose: Self-checking bench of the converter control registers
// Assumes: Short slew step parameter of 64 cycles
// Notes:   Pins and converter state driven by the bench
`timescale 1ns/1ps
module tb
    import pmcr_pkg::*;
;
    localparam pmcr_pins_s IDLE = 8'hf8;    // All enables high, no events
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        wr, rd;                    // Host strobes
    logic [7:0]  addr, wdata, rdata;        // Host bus
    pmcr_pins_s  pins = IDLE;               // Device pins
    logic [2:0]  conv_en = 3'h7;            // Converters enabled
    logic        aux_on, src, busy;         // Status outputs
    pmcr_conv_s  conv;                      // Converter controls
    logic [4:0]  code;                      // Internal ramp code
    logic [10:0] mv;                        // Rail millivolts from the ramp code
    int          n_errors = 0, n_compared = 0, cycles = 0, n;

    pmcr_converter_regs #(.STEP_CYCLES_SLOW(64)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .pins_i(pins), .conv_enabled_i(conv_en),
        .aux_regulator_one_on_o(aux_on), .conv_o(conv), .core_code_o(code),
        .core_rail_voltage_mv_o(mv), .core_pin_source_o(src), .dvm_busy_o(busy));
    pmcr_host_model host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata));

    // Clock and hang guard
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk({3'h0, d}, {3'h0, exp});
    endtask : rchk

    // Pins change, then settle through event and register stages
    task automatic setp(input pmcr_pins_s p);
        @(posedge clk_i);
        pins <= p;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : setp

    task automatic t_reset();
        rchk(ADDR_AUX_ENABLE, 8'h02);
        rchk(ADDR_PHASE_MODE, RST_PHASE_MODE);
        rchk(ADDR_DVM_DISCH, RST_DVM_DISCH);
        rchk(ADDR_CORE_CODE, 8'h14);
        rchk(ADDR_SLEW, {5'h00, RST_SLEW});
        rchk(8'h09, 8'h00);
        chk({10'h0, src}, 11'h1);
    endtask : t_reset

    // Three of the four phase codes on the second and third converters, ripple and fixed frequency
    task automatic t_phase();
        logic [7:0] v [3] = '{8'h6e, 8'hf8, 8'h00};
        foreach (v[i]) begin
            host.wr(ADDR_PHASE_MODE, v[i]);
            rchk(ADDR_PHASE_MODE, v[i]);
            chk({1'b0, conv[12:3]}, {3'h0, v[i]});
        end
    endtask : t_phase

    task automatic t_discharge();
        conv_en <= 3'b010;
        host.wr(ADDR_DVM_DISCH, 8'h7f);
        rchk(ADDR_DVM_DISCH, 8'h47);
        chk({8'h0, conv.discharge}, 11'h5);
        conv_en <= 3'h7;
        repeat (3) @(posedge clk_i);
        #1;
        chk({8'h0, conv.discharge}, 11'h0);
    endtask : t_discharge

    // Reload events: four full ones, then each buck pin alone
    task automatic t_events();
        pmcr_pins_s p;
        for (int i = 0; i < 6; i++) begin
            host.wr(ADDR_DVM_DISCH, 8'h00);
            host.wr(ADDR_CORE_CODE, 8'h0b);
            rchk(ADDR_DVM_DISCH, 8'h00);
            chk({10'h0, src}, 11'h0);
            p = IDLE;
            case (i)
                0: p.warm_reset_n = 1'b0;
                1: p.por_active = 1'b1;
                2: p.backup_low = 1'b1;
                3: p = 8'hc8;
                4: p.buck_one_en = 1'b0;
                default: p.buck_three_en = 1'b0;
            endcase
            setp(p);
            setp(IDLE);
            rchk(ADDR_DVM_DISCH, (i < 4) ? 8'h40 : 8'h00);
            rchk(ADDR_CORE_CODE, (i < 4) ? 8'h14 : (i == 4) ? 8'h1a : 8'h0b);
        end
    endtask : t_events

    task automatic t_aux();
        setp(8'h78);
        host.wr(ADDR_AUX_ENABLE, 8'h00);
        rchk(ADDR_AUX_ENABLE, 8'h02);
        setp(IDLE);
        host.wr(ADDR_AUX_ENABLE, 8'h00);
        rchk(ADDR_AUX_ENABLE, 8'h00);
        chk({10'h0, aux_on}, 11'h0);
        host.wr(ADDR_AUX_ENABLE, 8'h02);
        setp(IDLE);
        chk({10'h0, aux_on}, 11'h1);
        setp(8'hb8);
        chk({10'h0, aux_on}, 11'h0);
        setp(IDLE);
    endtask : t_aux

    task automatic ramp(input logic [7:0] c, input logic [2:0] s);
        host.wr(ADDR_SLEW, {5'h00, s});
        host.wr(ADDR_CORE_CODE, c);
        host.wr(ADDR_DVM_DISCH, 8'h80);
        n = 0;
        while ((n < 3 || busy !== 1'b0) && n < 1000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask : ramp

    task automatic t_dvm();
        host.wr(ADDR_DVM_DISCH, 8'h00);
        ramp(8'h16, 3'h6);
        chk({6'h0, code}, 11'h16);
        chk(mv, 11'h546);
        rchk(ADDR_DVM_DISCH, 8'h00);
        ramp(8'h1f, SLEW_IMMEDIATE);
        chk({10'h0, n <= 6}, 11'h1);
        chk(mv, CORE_TOP_MV);
        ramp(8'h1d, 3'h0);
        chk({10'h0, n >= 126 && n <= 140}, 11'h1);
        chk({6'h0, code}, 11'h1d);
    endtask : t_dvm

    // Lockout in mid-ramp, select pin high
    task automatic t_lockout();
        host.wr(ADDR_CORE_CODE, 8'h10);
        host.wr(ADDR_DVM_DISCH, 8'h80);
        repeat (20) @(posedge clk_i);
        pins <= 8'hf9;
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rchk(ADDR_DVM_DISCH, 8'h40);
        rchk(ADDR_CORE_CODE, 8'h1e);
        chk({10'h0, busy}, 11'h0);
    endtask : t_lockout

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_phase();
        t_discharge();
        t_events();
        t_aux();
        t_dvm();
        t_lockout();
        test_done();
    end
endmodule : tb
